// >>> external_irq_front_end.sv
/*
 * External request front end: pin routing, synchronisers, sense and
 * pending flags, enables, standby wake-up, default and level priority
 * with fixed vectors, and transfer controller triggers.
 * Assumes peripheral flags and standby level are synchronous inputs on mclk and a
 * single-cycle register port with read data one cycle after the strobe.
 */
// Decided for this implementation: the plain strobed port and the placing of the registers.
`default_nettype none

module external_irq_front_end
	import irq_front_pkg::*;
#(
	parameter int LINES = 16,
	parameter int PERIPH = 4,
	parameter int SETTLE_CYCLES = SETTLE_CYC
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire irq_front_pkg::reg_req_s reg_req,
	output logic [irq_front_pkg::DATA_W-1:0] reg_rdata,
	input wire logic [LINES-1:0] pin_a,
	input wire logic [LINES-1:0] pin_b,
	input wire logic nmi_pin,
	input wire logic [PERIPH-1:0] periph_flag,
	input wire logic standby,
	input wire logic cpu_ack,
	input wire logic [7:0] ack_vector,
	output logic irq_req,
	output logic [7:0] irq_vector,
	output logic [15:0] irq_vaddr,
	output logic nmi_req,
	output logic [LINES+PERIPH-1:0] xfer_req,
	output logic wake
);
	import irq_front_pkg::*;

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (LINES != 8 && LINES != 16) begin : g_bad_lines
		$error("LINES must be 8 or 16");
	end
	if (PERIPH < 1 || PERIPH > 4) begin : g_bad_periph
		$error("PERIPH must be 1 to 4");
	end
	if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535) begin : g_bad_settle
		$error("SETTLE_CYCLES out of range");
	end

	localparam logic [DATA_W-1:0] LMASK =
		(LINES == 16) ? MASK_FULL : MASK_REDUCED;
	localparam int NPRIO = LINES / 4;

	function automatic logic sense_hit(input logic [1:0] sc,
		input logic cur, input logic prev);
		logic hit;
		hit = 1'b0;
		unique case (sense_e'(sc))
			SENSE_LOW: hit = ~cur;
			SENSE_FALL: hit = prev & ~cur;
			SENSE_RISE: hit = ~prev & cur;
			SENSE_BOTH: hit = prev ^ cur;
		endcase
		return hit;
	endfunction

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] control_r;
	logic [2*DATA_W-1:0] sense_r;
	logic [DATA_W-1:0] line_en_r;
	logic [DATA_W-1:0] pend_r;
	logic [DATA_W-1:0] pend_nxt;
	logic [DATA_W-1:0] route_r;
	logic [DATA_W-1:0] wake_en_r;
	logic [DATA_W-1:0] prio_r [4];
	logic [DATA_W-1:0] periph_prio_r;
	logic [DATA_W-1:0] periph_en_r;
	logic [DATA_W-1:0] rdata_r;
	logic nmi_pend_r;
	logic nmi_pend_nxt;

	wire wr_ctl = reg_req.wr && reg_req.addr == OFS_CONTROL;
	wire wr_slo = reg_req.wr && reg_req.addr == OFS_SENSE_LO;
	wire wr_shi = reg_req.wr && reg_req.addr == OFS_SENSE_HI;
	wire wr_len = reg_req.wr && reg_req.addr == OFS_LINE_EN;
	wire wr_sts = reg_req.wr && reg_req.addr == OFS_STATUS;
	wire wr_rte = reg_req.wr && reg_req.addr == OFS_PIN_ROUTE;
	wire wr_wke = reg_req.wr && reg_req.addr == OFS_WAKE_EN;
	wire wr_ppr = reg_req.wr && reg_req.addr == OFS_PERIPH_PRIO;
	wire wr_pen = reg_req.wr && reg_req.addr == OFS_PERIPH_EN;
	wire [DATA_W-1:0] wmask = reg_req.wdata & LMASK;
	wire mode2 = control_r[CTL_MODE2_BIT];
	wire nmi_rising = control_r[CTL_NMI_EDGE_BIT];

	// ----------------------------------------------------------------
	// Pin routing, synchronisers and detection
	// ----------------------------------------------------------------
	logic [LINES-1:0] sync1_r, sync2_r, sync3_r;
	logic [LINES-1:0] line_hit;
	logic [LINES-1:0] line_clr_ack;
	logic [LINES-1:0] line_req;
	logic [LINES-1:0] sampled;
	logic [LVL_W-1:0] line_lvl [LINES];
	logic nsync1_r, nsync2_r, nsync3_r;
	wire asleep = standby;

	// Routing ahead of the synchroniser: a route change may look like
	// an edge, so software changes it with the line disabled.
	wire [LINES-1:0] routed = (route_r[LINES-1:0] & pin_b) |
		(~route_r[LINES-1:0] & pin_a);

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sync1_r <= '1;
			sync2_r <= '1;
			sync3_r <= '1;
			nsync1_r <= 1'b1;
			nsync2_r <= 1'b1;
			nsync3_r <= 1'b1;
		end else begin
			sync1_r <= routed;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			nsync1_r <= nmi_pin;
			nsync2_r <= nsync1_r;
			nsync3_r <= nsync2_r;
		end
	end

	for (genvar i = 0; i < LINES; i++) begin : g_line
		localparam logic [7:0] VEC = VEC_LINE0 + 8'(i);
		assign sampled[i] = ~asleep | wake_en_r[i];
		assign line_hit[i] = sampled[i] &
			sense_hit(sense_r[2*i+:2], sync2_r[i], sync3_r[i]);
		// Level lines keep their flag while the pin is still low.
		assign line_clr_ack[i] = cpu_ack && ack_vector == VEC &&
			(sense_r[2*i+:2] != 2'(SENSE_LOW) || sync2_r[i]);
		assign line_req[i] = pend_r[i] & line_en_r[i];
		assign line_lvl[i] = mode2 ?
			prio_r[i/4][LVL_TOP-LVL_STRIDE*(i%4)-:LVL_W] : '0;
	end

	wire nmi_edge = nmi_rising ? (nsync2_r & ~nsync3_r) :
		(~nsync2_r & nsync3_r);
	wire [LINES-1:0] wake_hits = line_hit & wake_en_r[LINES-1:0];

	// Set wins over a clear arriving in the same cycle.
	always_comb begin
		pend_nxt = pend_r;
		if (wr_sts) begin
			pend_nxt = pend_nxt & reg_req.wdata;
		end
		pend_nxt[LINES-1:0] = (pend_nxt[LINES-1:0] & ~line_clr_ack) |
			line_hit;
		pend_nxt = pend_nxt & LMASK;
		nmi_pend_nxt = (nmi_pend_r &
			~(cpu_ack && ack_vector == VEC_NMI)) | nmi_edge;
	end

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			control_r <= CONTROL_RST;
			sense_r <= '0;
			line_en_r <= '0;
			route_r <= ROUTE_RST;
			wake_en_r <= WAKE_RST;
			periph_prio_r <= PRIO_RST;
			periph_en_r <= '0;
		end else begin
			if (wr_ctl) control_r <= reg_req.wdata & 16'h0003;
			if (wr_slo) sense_r[DATA_W-1:0] <= reg_req.wdata;
			if (wr_shi) sense_r[2*DATA_W-1:DATA_W] <=
				(LINES == 16) ? reg_req.wdata : '0;
			if (wr_len) line_en_r <= wmask;
			if (wr_rte) route_r <= wmask;
			if (wr_wke) wake_en_r <= wmask;
			if (wr_ppr) periph_prio_r <= reg_req.wdata;
			if (wr_pen) periph_en_r <= reg_req.wdata &
				16'((1 << PERIPH) - 1);
		end
	end

	for (genvar p = 0; p < 4; p++) begin : g_prio
		wire wr_p = reg_req.wr &&
			reg_req.addr == OFS_PRIO_BASE + 8'(p) && p < NPRIO;
		always_ff @(posedge mclk or negedge rstn) begin
			if (!rstn) begin
				prio_r[p] <= PRIO_RST;
			end else if (wr_p) begin
				prio_r[p] <= reg_req.wdata & 16'h7777;
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pend_r <= '0;
			nmi_pend_r <= 1'b0;
		end else begin
			pend_r <= pend_nxt;
			nmi_pend_r <= nmi_pend_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Peripheral sources
	// ----------------------------------------------------------------
	logic [PERIPH-1:0] periph_req;
	logic [LVL_W-1:0] periph_lvl [PERIPH];
	for (genvar k = 0; k < PERIPH; k++) begin : g_periph
		assign periph_req[k] = periph_flag[k] & periph_en_r[k];
		assign periph_lvl[k] = mode2 ?
			periph_prio_r[LVL_TOP-LVL_STRIDE*k-:LVL_W] : '0;
	end

	// ----------------------------------------------------------------
	// Priority and vector selection
	// ----------------------------------------------------------------
	logic best_any;
	logic [LVL_W-1:0] best_lvl;
	logic [7:0] best_vec;

	// Scanned in ascending vector order; only a strictly higher level
	// displaces, so equal levels keep the lower vector.
	always_comb begin
		best_any = 1'b0;
		best_lvl = '0;
		best_vec = '0;
		for (int i = 0; i < LINES; i++) begin
			if (line_req[i] && (!best_any || line_lvl[i] > best_lvl)) begin
				best_any = 1'b1;
				best_lvl = line_lvl[i];
				best_vec = VEC_LINE0 + 8'(i);
			end
		end
		for (int k = 0; k < PERIPH; k++) begin
			if (periph_req[k] &&
				(!best_any || periph_lvl[k] > best_lvl)) begin
				best_any = 1'b1;
				best_lvl = periph_lvl[k];
				best_vec = VEC_PERIPH0 + 8'(k);
			end
		end
		if (nmi_pend_r) begin
			best_any = 1'b1;
			best_vec = VEC_NMI;
		end
	end

	wire [15:0] best_vaddr = (best_vec == VEC_NMI) ? VADDR_NMI :
		{6'b00_0000, best_vec, 2'b00};

	logic irq_req_r;
	logic [7:0] irq_vector_r;
	logic [15:0] irq_vaddr_r;
	logic [LINES+PERIPH-1:0] xfer_r;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			irq_req_r <= 1'b0;
			irq_vector_r <= '0;
			irq_vaddr_r <= '0;
			xfer_r <= '0;
		end else begin
			irq_req_r <= best_any;
			irq_vector_r <= best_vec;
			irq_vaddr_r <= best_vaddr;
			xfer_r <= {periph_req, line_req};
		end
	end

	// ----------------------------------------------------------------
	// Software standby wake-up
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_RUN,
		ST_SLEEP,
		ST_SETTLE
	} wake_state_e;

	wake_state_e wst_r, wst_nxt;
	logic [15:0] settle_r, settle_nxt;
	logic wake_r, wake_nxt;
	// The nonmaskable line and each line enabled in wake_en_r count as wake sources.
	wire wake_event = (|wake_hits) | nmi_edge;

	always_comb begin
		wst_nxt = wst_r;
		settle_nxt = settle_r;
		wake_nxt = 1'b0;
		unique case (wst_r)
			ST_RUN: begin
				if (standby) wst_nxt = ST_SLEEP;
			end
			ST_SLEEP: begin
				if (wake_event) begin
					wst_nxt = ST_SETTLE;
					settle_nxt = 16'(SETTLE_CYCLES - 1);
				end else if (!standby) begin
					wst_nxt = ST_RUN;
				end
			end
			ST_SETTLE: begin
				if (settle_r == '0) begin
					wake_nxt = 1'b1;
					wst_nxt = ST_RUN;
				end else begin
					settle_nxt = settle_r - 16'h0001;
				end
			end
		endcase
	end

	// Settle cannot be cut short: a leave-standby before the count is
	// out would run the core on an unsettled oscillator.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			wst_r <= ST_RUN;
			settle_r <= '0;
			wake_r <= 1'b0;
		end else begin
			wst_r <= wst_nxt;
			settle_r <= settle_nxt;
			wake_r <= wake_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Register reads
	// ----------------------------------------------------------------
	wire [DATA_W-1:0] state_word = {irq_req_r, nmi_pend_r, 4'h0,
		2'(wst_r), irq_vector_r};
	wire [1:0] pidx = 2'(reg_req.addr - OFS_PRIO_BASE);
	wire is_prio = reg_req.addr >= OFS_PRIO_BASE &&
		reg_req.addr < OFS_PRIO_BASE + 8'(NPRIO);
	wire [DATA_W-1:0] rd_mux =
		(reg_req.addr == OFS_CONTROL) ? control_r :
		(reg_req.addr == OFS_SENSE_LO) ? sense_r[DATA_W-1:0] :
		(reg_req.addr == OFS_SENSE_HI) ? sense_r[2*DATA_W-1:DATA_W] :
		(reg_req.addr == OFS_LINE_EN) ? line_en_r :
		(reg_req.addr == OFS_STATUS) ? pend_r :
		(reg_req.addr == OFS_PIN_ROUTE) ? route_r :
		(reg_req.addr == OFS_WAKE_EN) ? wake_en_r :
		is_prio ? prio_r[pidx] :
		(reg_req.addr == OFS_PERIPH_PRIO) ? periph_prio_r :
		(reg_req.addr == OFS_PERIPH_EN) ? periph_en_r :
		(reg_req.addr == OFS_STATE) ? state_word : '0;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= reg_req.rd ? rd_mux : '0;
		end
	end

	assign reg_rdata = rdata_r;
	assign irq_req = irq_req_r;
	assign irq_vector = irq_vector_r;
	assign irq_vaddr = irq_vaddr_r;
	assign nmi_req = nmi_pend_r;
	assign xfer_req = xfer_r;
	assign wake = wake_r;

endmodule // external_irq_front_end

`default_nettype wire

// >>> irq_front_pkg.sv
/*
 * Shared constants and carriers of the external request front end:
 * register offsets, reset values, sense codes, vector numbers, timing.
 * Assumes a 10 MHz system clock and a 16-bit register port.
 */
`default_nettype none

package irq_front_pkg;

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;

	localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_SENSE_LO = 8'h02;
	localparam logic [ADDR_W-1:0] OFS_SENSE_HI = 8'h03;
	localparam logic [ADDR_W-1:0] OFS_LINE_EN = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h05;
	localparam logic [ADDR_W-1:0] OFS_PIN_ROUTE = 8'h06;
	localparam logic [ADDR_W-1:0] OFS_WAKE_EN = 8'h07;
	localparam logic [ADDR_W-1:0] OFS_PRIO_BASE = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_PERIPH_PRIO = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_PERIPH_EN = 8'h0D;
	localparam logic [ADDR_W-1:0] OFS_STATE = 8'h0E;

	// ----------------------------------------------------------------
	// Fields and reset values
	// ----------------------------------------------------------------
	localparam int CTL_NMI_EDGE_BIT = 0;
	localparam int CTL_MODE2_BIT = 1;
	localparam logic [DATA_W-1:0] CONTROL_RST = 16'h0000;
	localparam logic [DATA_W-1:0] ROUTE_RST = 16'h0000;
	localparam logic [DATA_W-1:0] WAKE_RST = 16'h0007;
	localparam logic [DATA_W-1:0] PRIO_RST = 16'h7777;
	localparam logic [DATA_W-1:0] MASK_FULL = 16'hFFFF;
	localparam logic [DATA_W-1:0] MASK_REDUCED = 16'h00FF;
	localparam int LVL_W = 3;
	localparam int LVL_STRIDE = 4;
	localparam int LVL_TOP = 14;

	typedef enum logic [1:0] {
		SENSE_LOW = 2'b00,
		SENSE_FALL = 2'b01,
		SENSE_RISE = 2'b10,
		SENSE_BOTH = 2'b11
	} sense_e;

	// ----------------------------------------------------------------
	// Vectors
	// ----------------------------------------------------------------
	localparam logic [7:0] VEC_NMI = 8'h07;
	localparam logic [7:0] VEC_LINE0 = 8'h10;
	localparam logic [7:0] VEC_PERIPH0 = 8'h20;
	localparam logic [15:0] VADDR_NMI = 16'h001C;
	localparam logic [15:0] VADDR_LINE0 = 16'h0040;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 10_000_000;
	localparam int SETTLE_US = 8;
	localparam int SETTLE_CYC = SETTLE_US * (CLK_HZ / 1_000_000);

endpackage

`default_nettype wire

// >>> external_irq_front_end_asserts.sv
/*
 * Port checker for the external request front end.
 * Assumes the design package and a settling count of 4 in simulation.
 */
`default_nettype none

module external_irq_front_end_asserts
	import irq_front_pkg::*;
#(
	parameter int LINES = 16,
	parameter int PERIPH = 4,
	parameter int SETTLE_CYCLES = 4
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire irq_front_pkg::reg_req_s reg_req,
	input wire logic standby,
	input wire logic irq_req,
	input wire logic [7:0] irq_vector,
	input wire logic [15:0] irq_vaddr,
	input wire logic nmi_req,
	input wire logic [LINES+PERIPH-1:0] xfer_req,
	input wire logic wake
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	// Mode shadow: the winner depends on it
	logic mode2_r;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			mode2_r <= 1'b0;
		else if (reg_req.wr && reg_req.addr == OFS_CONTROL)
			mode2_r <= reg_req.wdata[CTL_MODE2_BIT];
	end

	a_vaddr_fixed: assert property (
		irq_req |-> irq_vaddr == {6'h00, irq_vector, 2'b00})
		else $error("vector address not four times vector");
	a_line_vaddr: assert property (
		irq_req && irq_vector == VEC_LINE0 |-> irq_vaddr == VADDR_LINE0)
		else $error("line 0 vector address wrong");
	a_nmi_wins: assert property (
		nmi_req && $past(nmi_req) |-> irq_req && irq_vector == VEC_NMI)
		else $error("nonmaskable request not on top");
	a_line0_first: assert property (
		irq_req && !mode2_r && !$past(mode2_r) && xfer_req[0] &&
		!nmi_req && !$past(nmi_req)
		|-> irq_vector == VEC_LINE0)
		else $error("line 0 lost default order");
	a_req_gated: assert property (
		!nmi_req && !$past(nmi_req) |-> irq_req == (|xfer_req))
		else $error("request without enabled pending source");
	a_wake_pulse: assert property (
		wake |=> !wake)
		else $error("wake longer than one cycle");
	a_wake_standby: assert property (
		wake |-> standby && $past(standby, 5))
		else $error("wake outside standby");
	a_wake_settle: assert property (
		$rose(standby) |=> !wake [*4])
		else $error("wake before settling time");
endmodule // external_irq_front_end_asserts

bind external_irq_front_end external_irq_front_end_asserts #(
	.LINES(LINES), .PERIPH(PERIPH), .SETTLE_CYCLES(SETTLE_CYCLES)
) chk_inst (
	.mclk(mclk), .rstn(rstn), .reg_req(reg_req), .standby(standby),
	.irq_req(irq_req), .irq_vector(irq_vector), .irq_vaddr(irq_vaddr),
	.nmi_req(nmi_req), .xfer_req(xfer_req), .wake(wake)
);

`default_nettype wire

// >>> cpu_core_model.sv
/*
 * Behavioural CPU core: accepts vectored requests when allowed to.
 * Assumes requests are registered levels that drop after an ack.
 */
`default_nettype none

module cpu_core_model (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic go,
	input wire logic irq_req,
	input wire logic [7:0] irq_vector,
	output logic cpu_ack,
	output logic [7:0] ack_vector
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] cnt_r;

	// Holdoff after ack lets the request level settle before re-arming
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cnt_r <= 3'h0;
			cpu_ack <= 1'b0;
			ack_vector <= 8'h00;
		end else begin
			cpu_ack <= (cnt_r == 3'h4);
			// Vector line is garbage outside the ack pulse
			ack_vector <= (cnt_r == 3'h4) ? irq_vector : ~ack_vector;
			if (cnt_r != 3'h0)
				cnt_r <= cnt_r - 3'h1;
			else if (go && irq_req)
				cnt_r <= 3'h7;
		end
	end
endmodule // cpu_core_model

`default_nettype wire

// >>> external_irq_front_end_bench.sv
/*
 * Self-checking bench for the external request front end.
 * Assumes pins idle high and a CPU model on the vectored side.
 */
`default_nettype none

module external_irq_front_end_bench import irq_front_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk, rstn, standby, nmi_pin, go, cpu_ack, irq_req, nmi_req, wake;
	reg_req_s req;
	logic [15:0] reg_rdata, pin_a, pin_b, irq_vaddr;
	logic [3:0] periph_flag;
	logic [7:0] ack_vector, irq_vector;
	logic [19:0] xfer_req;
	int failures, n_checks, n_wake, m;

	external_irq_front_end #(.LINES(16), .PERIPH(4), .SETTLE_CYCLES(4))
	external_irq_front_end_inst (.mclk(mclk), .rstn(rstn), .reg_req(req),
		.reg_rdata(reg_rdata), .pin_a(pin_a), .pin_b(pin_b),
		.nmi_pin(nmi_pin), .periph_flag(periph_flag), .standby(standby),
		.cpu_ack(cpu_ack), .ack_vector(ack_vector), .irq_req(irq_req),
		.irq_vector(irq_vector), .irq_vaddr(irq_vaddr), .nmi_req(nmi_req),
		.xfer_req(xfer_req), .wake(wake));
	cpu_core_model cpu_core_model_inst (.mclk(mclk), .rstn(rstn), .go(go),
		.irq_req(irq_req), .irq_vector(irq_vector), .cpu_ack(cpu_ack),
		.ack_vector(ack_vector));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk) req <= {a, d, 2'b10};
		@(posedge mclk) req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge mclk) req <= {a, 16'h0000, 2'b01};
		@(posedge mclk) req.rd <= 1'b0;
		#1 chk(reg_rdata, exp);
		// Back on the edge, so later stimulus stays edge aligned
		@(posedge mclk);
	endtask
	task automatic results();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	always @(posedge mclk) if (wake) n_wake <= n_wake + 1;
	// Tests need about 300 cycles; allow sixteen times that
	initial begin
		#500000 failures++;
		results();
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		rstn = 1'b0;
		req = '0;
		pin_a = 16'hFFFF;
		pin_b = 16'hFFFF;
		nmi_pin = 1'b1;
		standby = 1'b0;
		go = 1'b0;
		periph_flag = 4'h0;
		failures = 0;
		n_checks = 0;
		wt(4);
		rstn <= 1'b1;
		rd(OFS_PIN_ROUTE, 16'h0000);
		rd(OFS_WAKE_EN, 16'h0007);
		wr(OFS_PIN_ROUTE, 16'hA5A5);
		rd(OFS_PIN_ROUTE, 16'hA5A5);
		$display("test registers done");
		wr(OFS_PIN_ROUTE, 16'h0000);
		wr(OFS_LINE_EN, 16'h0001);
		for (m = 0; m < 4; m++) begin
			wr(OFS_SENSE_LO, 16'(m));
			pin_a[0] <= 1'b0;
			wt(6);
			wr(OFS_STATUS, 16'hFFFF);
			rd(OFS_STATUS, 16'(m != 2));
			wr(OFS_STATUS, 16'h0000);
			rd(OFS_STATUS, 16'(m == 0));
			pin_a[0] <= 1'b1;
			wt(6);
			rd(OFS_STATUS, 16'(m == 0 || m >= 2));
			wr(OFS_STATUS, 16'h0000);
			rd(OFS_STATUS, 16'h0000);
		end
		$display("test sense done");
		wr(OFS_SENSE_LO, 16'h0004);
		wr(OFS_LINE_EN, 16'h0002);
		wr(OFS_PIN_ROUTE, 16'h0002);
		pin_a[1] <= 1'b0;
		wt(6);
		rd(OFS_STATUS, 16'h0000);
		pin_b[1] <= 1'b0;
		wt(6);
		rd(OFS_STATUS, 16'h0002);
		pin_a[1] <= 1'b1;
		pin_b[1] <= 1'b1;
		wr(OFS_STATUS, 16'h0000);
		wr(OFS_PIN_ROUTE, 16'h0000);
		$display("test route done");
		wr(OFS_SENSE_LO, 16'h0041);
		wr(OFS_LINE_EN, 16'h0009);
		standby <= 1'b1;
		wt(3);
		pin_a[3] <= 1'b0;
		wt(10);
		chk(n_wake, 0);
		pin_a[3] <= 1'b1;
		wt(3);
		pin_a[0] <= 1'b0;
		wt(12);
		chk(n_wake, 1);
		standby <= 1'b0;
		pin_a[0] <= 1'b1;
		rd(OFS_STATUS, 16'h0001);
		wr(OFS_STATUS, 16'h0000);
		$display("test standby done");
		wr(OFS_PERIPH_EN, 16'h0001);
		periph_flag <= 4'h3;
		wt(4);
		chk(xfer_req[19:16], 4'h1);
		periph_flag <= 4'h0;
		wr(OFS_PERIPH_EN, 16'h0000);
		$display("test peripheral done");
		wr(OFS_CONTROL, 16'h0001);
		wr(OFS_SENSE_LO, 16'h0005);
		wr(OFS_LINE_EN, 16'h0003);
		pin_a[1:0] <= 2'b00;
		wt(6);
		chk(irq_vector, 8'h10);
		nmi_pin <= 1'b0;
		wt(6);
		chk(nmi_req, 1'b0);
		nmi_pin <= 1'b1;
		wt(6);
		chk({nmi_req, irq_vector}, 9'h107);
		chk(irq_vaddr, 16'h001C);
		go <= 1'b1;
		wt(40);
		chk(irq_req, 1'b0);
		rd(OFS_STATUS, 16'h0000);
		$display("test priority done");
		go <= 1'b0;
		pin_a[1:0] <= 2'b11;
		wr(OFS_PRIO_BASE, 16'h0500);
		wr(OFS_CONTROL, 16'h0003);
		pin_a[1:0] <= 2'b00;
		wt(6);
		chk(irq_vector, 8'h11);
		chk(xfer_req[1:0], 2'b11);
		wr(OFS_PRIO_BASE, 16'h5500);
		wt(3);
		chk(irq_vector, 8'h10);
		$display("test levels done");
		results();
	end
endmodule // external_irq_front_end_bench

`default_nettype wire
